/* File: msbs_port.sv */
// simple-bus management slave port, top level
`default_nettype none
`include "msbs_params.svh"
// Function
// - select low: direction flag ignored
// - select high, flag low: write
// - select high, flag high: read
// - addressed register returned on read data
// - read acknowledge marks read completion
// - separate write acknowledge marks write completion
// - error only alongside an acknowledge
module msbs_port
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  input  wire logic                 portSelect,
  input  wire logic                 readNotWriteFlag,
  input  wire msbs_pkg::msbs_addr_t registerAddressIn,
  input  wire msbs_pkg::msbs_word_t writeDataIn,
  output var  msbs_pkg::msbs_word_t readDataOut,
  output logic                      readAcknowledge,
  output logic                      writeAcknowledge,
  output logic                      transactionError
);
  import msbs_pkg::*;

  // ****************************************
  // address map and transfer walk
  // ****************************************
  // byte addresses, whole 32-bit words only, no byte lanes:
  //   0x00  status, read only: controller state, one-hot
  //   0x04  request count, read only: requests taken so far
  //   0x08  first scratch word, read/write, clears on reset
  //   ....  scratch words continue every four bytes
  //   0x1c  last scratch word
  // refused requests:
  //   any address with either of its low two bits set
  //   any address at 0x20 or above
  //   any write to one of the two read-only words
  // a refused request still gets its acknowledge, with the error
  // flag high in that same cycle only; a refused write stores
  // nothing and a refused read returns zero
  //
  // write walk:
  //   edge 0  select high, flag low, address and data standing;
  //           the word is stored at this edge
  //   edge 1  write acknowledge high for one cycle
  //   edge 2  select seen low, controller back in idle
  // read walk:
  //   edge 0  select high, flag high, address standing
  //   edge 1  read acknowledge high, read data valid
  //   edge 2  select seen low, controller back in idle
  // read data then holds until the next read acknowledge
  //
  // hazards:
  //   the master must drop select for one edge after an acknowledge;
  //   while select stays high nothing new is taken, so a slow master
  //   never sees a second acknowledge for one request
  //   the request count reads the value before its own request
  //   clock enable low freezes every register, acknowledges too,
  //   so a pulse lasts for as long as the enable stays low

  // ****************************************
  // decode helpers
  // ****************************************
  // address valid: aligned and inside the map
  function automatic logic addrOk(input msbs_addr_t a);
    addrOk = (a[1:0] == 2'h0)
          && (a[`MSBS_ADDR_W-1:`MSBS_IDX_LSB+`MSBS_IDX_W] == '0);
  endfunction

  function automatic msbs_idx_t addrIdx(input msbs_addr_t a);
    addrIdx = a[`MSBS_IDX_LSB+`MSBS_IDX_W-1:`MSBS_IDX_LSB];
  endfunction

  // write refused: bad address or a read-only word
  function automatic logic wrRefused(input msbs_addr_t a);
    wrRefused = !addrOk(a) || (addrIdx(a) < `MSBS_RO_LIMIT);
  endfunction

  // controller, answer, counter and decode signals
  msbs_state_t state_q, state_d;
  msbs_word_t  rdData_q, rdData_d;
  logic        rdAck_q, rdAck_d;
  logic        wrAck_q, wrAck_d;
  logic        err_q, err_d;
  msbs_word_t  count_q, count_d;
  logic        wrEn;
  msbs_word_t  rdWord;
  msbs_word_t  statusWord;
  logic        take;

  // ****************************************
  // transaction control
  // ****************************************
  // a request is taken in idle, answered next cycle, then waits for select to drop
  always_comb
  begin
    state_d  = state_q;
    rdAck_d  = 1'b0;
    wrAck_d  = 1'b0;
    err_d    = 1'b0;
    wrEn     = 1'b0;
    unique case (state_q)
      MSBS_IDLE:
      begin
        if (portSelect)
        begin
          if (readNotWriteFlag)
          begin
            state_d  = MSBS_READ;
            rdAck_d  = 1'b1;
            err_d    = !addrOk(registerAddressIn);
          end
          else
          begin
            state_d = MSBS_WRITE;
            wrAck_d = 1'b1;
            err_d   = wrRefused(registerAddressIn);
            wrEn    = !err_d;
          end
        end
      end
      MSBS_READ,
      MSBS_WRITE:
      begin
        // hold off until the master lets go so each request acks once
        if (!portSelect)
          state_d = MSBS_IDLE;
      end
      default:
        state_d = MSBS_IDLE;
    endcase
  end

  // registers; reset keeps every output low
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q  <= MSBS_IDLE;
      rdAck_q  <= 1'b0;
      wrAck_q  <= 1'b0;
      err_q    <= 1'b0;
    end
    else if (ce)
    begin
      state_q  <= state_d;
      rdAck_q  <= rdAck_d;
      wrAck_q  <= wrAck_d;
      err_q    <= err_d;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // a request is taken only from idle with select high
  assign take = (state_q == MSBS_IDLE) && portSelect;

  // capture the addressed word when a read is taken; refused reads give zero
  always_comb
  begin
    rdData_d = rdData_q;
    if (take && readNotWriteFlag)
      rdData_d = addrOk(registerAddressIn) ? rdWord : 32'h0;
  end

  // read data register; holds between reads, zero in reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdData_q <= `MSBS_RESET_VALUE;
    else if (ce)
      rdData_q <= rdData_d;
  end

  // ****************************************
  // request counter
  // ****************************************
  // count every taken request, good or refused
  always_comb
  begin
    count_d = count_q;
    if (take)
      count_d = count_q + 32'h1;
  end

  // counter register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      count_q <= `MSBS_RESET_VALUE;
    else if (ce)
      count_q <= count_d;
  end

  // status word shows the controller state
  assign statusWord = {29'h0, state_q};

  // word storage and read mux, indexed by the address
  msbs_regfile msbs_regfile_i
  (
    .clk        (clk),
    .rst        (sys_rst),
    .ce         (ce),
    .wrEn       (wrEn),
    .idx        (addrIdx(registerAddressIn)),
    .wrData     (writeDataIn),
    .statusWord (statusWord),
    .countWord  (count_q),
    .rdWord     (rdWord)
  );

  // outputs straight from flops
  assign readDataOut      = rdData_q;
  assign readAcknowledge  = rdAck_q;
  assign writeAcknowledge = wrAck_q;
  assign transactionError = err_q;
endmodule
`default_nettype wire

/* File: msbs_params.svh */
// constants for the management simple-bus slave port
`ifndef MSBS_PARAMS_SVH
`define MSBS_PARAMS_SVH

`define MSBS_DATA_W      32
`define MSBS_ADDR_W      32
`define MSBS_REG_COUNT   8
`define MSBS_IDX_LSB     2
`define MSBS_IDX_W       3
`define MSBS_RESET_VALUE 32'h0000_0000
// registers at index 0 and 1 are read-only state, the rest read/write
`define MSBS_RO_LIMIT    3'h2

`endif

/* File: msbs_pkg.sv */
// types for the management simple-bus slave port
`default_nettype none
`include "msbs_params.svh"
package msbs_pkg;
  typedef logic [`MSBS_DATA_W-1:0] msbs_word_t;
  typedef logic [`MSBS_ADDR_W-1:0] msbs_addr_t;
  typedef logic [`MSBS_IDX_W-1:0]  msbs_idx_t;
  typedef enum logic [2:0]
  {
    MSBS_IDLE  = 3'b001,
    MSBS_READ  = 3'b010,
    MSBS_WRITE = 3'b100
  } msbs_state_t;
endpackage
`default_nettype wire

/* File: msbs_regfile.sv */
// register storage for the management port
`default_nettype none
`include "msbs_params.svh"
module msbs_regfile
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               wrEn,
  input  wire msbs_pkg::msbs_idx_t idx,
  input  wire msbs_pkg::msbs_word_t wrData,
  input  wire msbs_pkg::msbs_word_t statusWord,
  input  wire msbs_pkg::msbs_word_t countWord,
  output var  msbs_pkg::msbs_word_t rdWord
);
  import msbs_pkg::*;

  msbs_word_t mem_q [`MSBS_REG_COUNT];
  msbs_word_t mem_d [`MSBS_REG_COUNT];

  // ****************************************
  // storage
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `MSBS_REG_COUNT; g++)
    begin : gen_reg
      // write steers one word
      always_comb
      begin
        mem_d[g] = mem_q[g];
        if (wrEn && idx == msbs_idx_t'(g))
          mem_d[g] = wrData;
      end
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          mem_q[g] <= `MSBS_RESET_VALUE;
        else if (ce)
          mem_q[g] <= mem_d[g];
      end
    end
  endgenerate

  // read mux: low indices show live state
  always_comb
  begin
    if (idx == 3'h0)
      rdWord = statusWord;
    else if (idx == 3'h1)
      rdWord = countWord;
    else
      rdWord = mem_q[idx];
  end
endmodule
`default_nettype wire

/* File: msbs_port_asserts.sv */
// checks on the management port
`default_nettype none
module msbs_port_asserts
(
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 portSelect,
  input wire logic                 readNotWriteFlag,
  input wire msbs_pkg::msbs_addr_t registerAddressIn,
  input wire msbs_pkg::msbs_word_t readDataOut,
  input wire logic                 readAcknowledge,
  input wire logic                 writeAcknowledge,
  input wire logic                 transactionError
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // short names; bad marks a request the port must refuse
  wire rd = readAcknowledge, wr = writeAcknowledge, er = transactionError;
  wire ack = rd | wr, sel = portSelect, rnw = readNotWriteFlag;
  wire bad = registerAddressIn[1:0] != 2'h0 || registerAddressIn >= 32'h20 ||
    !rnw && registerAddressIn < 32'h8;
  // acks tied to the request taken one edge earlier
  property p_rd; rd |-> $past(sel & rnw); endproperty
  a_rd: assert property (p_rd) else $error("stray rd ack");
  property p_wr; wr |-> $past(sel & !rnw); endproperty
  a_wr: assert property (p_wr) else $error("stray wr ack");
  property p_one; ack |-> !(rd & wr) ##1 !ack; endproperty
  a_one: assert property (p_one) else $error("ack shape");
  property p_take; $rose(sel) |=> ack; endproperty
  a_take: assert property (p_take) else $error("no ack");
  property p_dir; !sel |=> !ack; endproperty
  a_dir: assert property (p_dir) else $error("unselected ack");
  property p_err; er |-> ack && $past(bad); endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_bad; ack && $past(bad) |-> er; endproperty
  a_bad: assert property (p_bad) else $error("missing error");
  property p_hold; !rd |-> $stable(readDataOut); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  // main cases seen
  c_rd: cover property (rd && !er);
  c_wrEr: cover property (wr && er);
  c_rdEr: cover property (rd && er);
  c_held: cover property (sel && $past(wr));
endmodule
bind msbs_port msbs_port_asserts msbs_port_asserts_i (.*);
`default_nettype wire

/* File: msbs_master.sv */
// bus master model for the management port
`default_nettype none
module msbs_master
(
  input wire logic                 clk,
  input wire logic                 readAcknowledge,
  input wire logic                 writeAcknowledge,
  output var logic                 portSelect,
  output var logic                 readNotWriteFlag,
  output var msbs_pkg::msbs_addr_t registerAddressIn,
  output var msbs_pkg::msbs_word_t writeDataIn
);
  timeunit 1ns / 1ps;
  // bus idle at time zero
  initial {portSelect, readNotWriteFlag, registerAddressIn, writeDataIn} = '0;
  // whole word held until an ack and hold edges more, then lines released inverted
  task automatic xfer(input logic rnw, input logic [31:0] a, d, input int hold,
                      output logic ok, output int extra);
    int n;
    n     = 0;
    extra = 0;
    @(posedge clk);
    portSelect <= 1'h1;
    {readNotWriteFlag, registerAddressIn, writeDataIn} <= {rnw, a, d};
    @(posedge clk);
    while ((readAcknowledge | writeAcknowledge) !== 1'h1 && n < 8)
    begin
      n++;
      @(posedge clk);
    end
    ok = (readAcknowledge | writeAcknowledge) === 1'h1;
    // select kept high: any further ack is counted
    repeat (hold)
    begin
      @(posedge clk);
      if ((readAcknowledge | writeAcknowledge) !== 1'h0)
        extra++;
    end
    portSelect <= 1'h0;
    {readNotWriteFlag, registerAddressIn, writeDataIn} <= ~{rnw, a, d};
  endtask
endmodule
`default_nettype wire

/* File: tb_mgmt_simple_bus_slave_port.sv */
// self-checking bench for the management port
`default_nettype none
`include "msbs_params.svh"
module tb_mgmt_simple_bus_slave_port;
  timeunit 1ns / 1ps;
  import msbs_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, ce = 1'h1, portSelect, readNotWriteFlag, ok;
  logic readAcknowledge, writeAcknowledge, transactionError;
  msbs_addr_t registerAddressIn;
  msbs_word_t writeDataIn, readDataOut;
  int badCount, checked, extra;
  msbs_port msbs_port_i (.*);
  msbs_master msbs_master_i (.*);
  // clock
  initial forever #12.5 clk = ~clk;
  // compare and count
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    checked++;
    if (seen !== exp)
    begin
      badCount++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict
  task automatic endOfTest();
    if (badCount == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one transfer, judged at its ack edge
  task automatic io(input logic rnw, input logic [31:0] a, d, input logic e, input logic [31:0] q);
    msbs_master_i.xfer(rnw, a, d, 0, ok, extra);
    chk(ok, 1'h1, "ack");
    if (!ok) endOfTest();
    chk({30'h0, readAcknowledge, writeAcknowledge}, {30'h0, rnw, !rnw}, "ackKind");
    chk(transactionError, e, "err");
    if (rnw) chk(readDataOut, q, "data");
  endtask
  // read-only writes and bad addresses
  task automatic refusals();
    io(1'h0, 32'h0, 32'h1, 1'h1, 32'h0);
    io(1'h0, 32'h4, 32'h1, 1'h1, 32'h0);
    io(1'h1, 32'h9, 32'h0, 1'h1, 32'h0);
    io(1'h0, 32'h20, 32'h1, 1'h1, 32'h0);
    io(1'h1, 32'hffff_fffc, 32'h0, 1'h1, 32'h0);
  endtask
  // scratch words back to back
  task automatic scratch();
    for (int i = 8; i < 32; i += 4) io(1'h0, i, ~i, 1'h0, 32'h0);
    for (int i = 8; i < 32; i += 4) io(1'h1, i, 32'h0, 1'h0, ~i);
  endtask
  // select held past the ack: one ack only, word stored once
  task automatic heldSelect();
    msbs_master_i.xfer(1'h0, 32'h8, 32'h5a5a_0f0f, 3, ok, extra);
    chk(ok, 1'h1, "heldAck");
    if (!ok) endOfTest();
    chk(extra, 32'h0, "extraAck");
    io(1'h1, 32'h8, 32'h0, 1'h0, 32'h5a5a_0f0f);
  endtask
  // reset in mid-run
  task automatic midReset();
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    chk(readDataOut, 32'h0, "rstData");
    chk({29'h0, readAcknowledge, writeAcknowledge, transactionError}, 32'h0, "rstOut");
    sys_rst <= 1'h0;
    io(1'h1, 32'h1c, 32'h0, 1'h0, `MSBS_RESET_VALUE);
    io(1'h1, 32'h0, 32'h0, 1'h0, {29'h0, MSBS_IDLE});
    io(1'h1, 32'h4, 32'h0, 1'h0, 32'h2);
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    refusals();
    scratch();
    heldSelect();
    midReset();
    endOfTest();
  end
endmodule
`default_nettype wire
